// *** design/uart_rx_pkg.sv ***
// receive-side status and wake-up constants for the serial port block
// assumes a 100 MHz apb clock; shared by the design and the bench
package uart_rx_pkg;

  // apb register byte offsets
  localparam logic [7:0] STATUS_OFF = 8'h00; // uart_status_reg
  localparam logic [7:0] CTRL1_OFF = 8'h04; // uart_ctrl1_reg
  localparam logic [7:0] CTRL2_OFF = 8'h08; // uart_ctrl2_reg
  localparam logic [7:0] DATA_OFF = 8'h0c; // data_buffer_reg
  localparam logic [7:0] BAUD_OFF = 8'h10; // baud_divisor_reg
  localparam logic [7:0] SYS_OFF = 8'h14; // uart enable and interrupt enables

  // uart_status_reg fields
  localparam int ST_AVAIL = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_PARITY = 3;
  localparam int ST_FRAMING = 4;
  localparam int ST_RX_IDLE = 5;
  localparam int ST_TX_EMPTY = 6;
  localparam int ST_TX_IDLE = 7;

  // uart_ctrl1_reg fields
  localparam int C1_RX_BIT8 = 0;
  localparam int C1_TWO_STOP = 1;
  localparam int C1_PARITY_ODD = 2;
  localparam int C1_PARITY_EN = 3;
  localparam int C1_NINE_BIT = 4;

  // uart_ctrl2_reg fields
  localparam int C2_RX_INT_EN = 0;
  localparam int C2_TX_EMPTY_EN = 1;
  localparam int C2_TX_IDLE_EN = 2;
  localparam int C2_ADDR_DET = 3;
  localparam int C2_WAKE_EN = 4;

  // system control fields
  localparam int SYS_UART_ON = 0;
  localparam int SYS_RX_EN = 1;
  localparam int SYS_GLOBAL_IE = 2;
  localparam int SYS_UART_IE = 3;

  // reset values
  localparam logic [4:0] CTRL1_RST = 5'h00;
  localparam logic [4:0] CTRL2_RST = 5'h00;
  localparam logic [3:0] SYS_RST = 4'h0;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // oversampling: 16 ticks a bit, votes taken at ticks 7, 8 and 9
  localparam logic [3:0] OVS_FIRST = 4'h7;
  localparam logic [3:0] OVS_VOTE = 4'h9;
  localparam logic [3:0] OVS_LAST = 4'hf;

  // clock restart time after a pin wake-up
  localparam int CLK_PERIOD_NS = 10;
  localparam int STARTUP_NS = 1000;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // receiver states, gray along idle-start-data-stop
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b011,
    RX_STOP = 3'b010,
    RX_BREAK = 3'b110
  } rx_state_t;

endpackage : uart_rx_pkg

// *** design/uart_rx_status_and_wakeup.sv ***
// receiver, two-word receive buffer, error flags, interrupt pulse and pin wake-up
// assumes an apb master on pclk; tx status and clock-run level come from same-clock logic
//
// Functional notes
// - word moved to buffer sets data-available flag; interrupt if receive interrupt enable set
// - overrun also raises interrupt when receive interrupt enable set
// - buffer holds two words while third shifts; third completing sets overrun
// - on overrun buffered words are kept, shift register overwritten, flag set
// - overrun clears only after status access then data buffer read
// - noise flag rises with data-available; data still stored; no own interrupt
// - noise flag clears after status read then data buffer read
// - framing error when any expected stop bit samples low
// - framing and parity flags stored with the word; cleared by any reset
// - parity error only when parity enabled and received parity wrong
// - interrupt is a one-cycle low pulse from five sources
// - two transmit sources have own enables; two receive sources share one
// - status flags read-only; only the access sequence clears them
// - address detect: data interrupt only when highest received bit high
// - without address detect every data-available raises the interrupt
// - falling rx edge with clock stopped and enables set requests wake-up
// - stopped clock pauses reception; all registers keep contents
// - data on rx ignored during clock restart after wake-up
// - wake interrupt needs global and uart enables, only after start-up time
// - each bit voted from three samples at sixteen times baud rate
// - break sets data-available and framing, loads zeros, sets idle flag
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module uart_rx_status_and_wakeup #(
  parameter int STARTUP_CNT = uart_rx_pkg::STARTUP_CYCLES // clock restart cycles
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rx_pin, // serial receive pin, asynchronous
  input wire logic fh_running, // uart clock f_H running
  input wire logic tx_buf_empty, // transmitter buffer empty level
  input wire logic tx_idle, // transmitter idle level
  output logic uart_irq_n, // interrupt, one-cycle low pulse
  output logic wake_event // one-cycle wake-up request
);
  import uart_rx_pkg::*;

  localparam int STW = $clog2(STARTUP_CNT + 1);
  localparam logic [STW-1:0] STARTUP_LOAD = STW'(STARTUP_CNT);

  // register storage
  logic [4:0] ctrl1_q;
  logic [4:0] ctrl2_q;
  logic [3:0] sys_q;
  logic [7:0] baud_divisor_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_n_q;
  logic wake_q;

  // receive buffer: {noise, parity, framing, data[8:0]}
  logic [11:0] fifo_q [2];
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic overrun_q;
  logic clr_armed_q;

  // receiver
  rx_state_t state_q;
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_prev_q;
  logic [7:0] div_q;
  logic [3:0] ovs_q;
  logic [1:0] votes_q;
  logic vote_first_q;
  logic bit_val_q;
  logic noise_q;
  logic ferr_q;
  logic [3:0] field_q;
  logic stop_idx_q;
  logic [9:0] word_q;
  logic [STW-1:0] startup_q;
  logic wake_pend_q;
  logic tx_empty_prev_q;
  logic tx_idle_prev_q;

  // apb decode
  logic setup;
  logic access;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  always_comb begin
    setup = psel & ~penable;
    access = psel & penable & pready_q;
    wr_acc = access & pwrite;
    rd_acc = access & ~pwrite;
    mapped = (paddr == STATUS_OFF) | (paddr == CTRL1_OFF) | (paddr == CTRL2_OFF) |
             (paddr == DATA_OFF) | (paddr == BAUD_OFF) | (paddr == SYS_OFF);
  end

  // buffer head and derived flags
  logic [11:0] head;
  logic avail;
  logic rx_idle_flag;
  logic [7:0] status;
  logic pop;
  always_comb begin
    head = fifo_q[rd_ptr_q];
    avail = cnt_q != 2'd0;
    rx_idle_flag = (state_q == RX_IDLE) | (state_q == RX_BREAK);
    status = 8'h00;
    status[ST_AVAIL] = avail;
    status[ST_OVERRUN] = overrun_q;
    status[ST_NOISE] = avail & head[11];
    status[ST_PARITY] = avail & head[10];
    status[ST_FRAMING] = avail & head[9];
    status[ST_RX_IDLE] = rx_idle_flag;
    status[ST_TX_EMPTY] = tx_buf_empty;
    status[ST_TX_IDLE] = tx_idle;
    // only a data read following a status access pops the word
    pop = rd_acc & (paddr == DATA_OFF) & clr_armed_q & avail;
  end

  // apb answer: data and ready prepared in the setup cycle, zero wait in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        case (paddr)
          STATUS_OFF: prdata_q <= {24'h000000, status};
          CTRL1_OFF: prdata_q <= {27'h0000000, ctrl1_q[4:1], avail & head[8]};
          CTRL2_OFF: prdata_q <= {27'h0000000, ctrl2_q};
          DATA_OFF: prdata_q <= avail ? {23'h000000, head[8:0]} : 32'h0000_0000;
          BAUD_OFF: prdata_q <= {24'h000000, baud_divisor_q};
          SYS_OFF: prdata_q <= {28'h0000000, sys_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software-writable control; status and data are read-only here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      sys_q <= SYS_RST;
      baud_divisor_q <= BAUD_RST;
    end else if (wr_acc) begin
      case (paddr)
        CTRL1_OFF: ctrl1_q <= {pwdata[4:1], 1'b0}; // bit 0 is read-only
        CTRL2_OFF: ctrl2_q <= pwdata[4:0];
        BAUD_OFF: baud_divisor_q <= pwdata[7:0];
        SYS_OFF: sys_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // clear sequence: status access arms, next data read disarms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_armed_q <= 1'b0;
    end else if (access & (paddr == STATUS_OFF)) begin
      clr_armed_q <= 1'b1;
    end else if (rd_acc & (paddr == DATA_OFF)) begin
      clr_armed_q <= 1'b0;
    end
  end

  // pin synchroniser; only the second stage and its one-cycle delayed copy are looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  // gating: stopped clock pauses, restart window ignores the pin
  logic rx_on;
  logic run;
  logic tick;
  logic fall;
  always_comb begin
    rx_on = sys_q[SYS_UART_ON] & sys_q[SYS_RX_EN];
    run = rx_on & fh_running & (startup_q == '0);
    tick = run & (div_q == 8'h00);
    fall = rx_prev_q & ~rx_sync_q;
  end

  // 16x baud enable divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (!run) begin
      div_q <= div_q; // hold phase across a pause
    end else if (div_q == 8'h00) begin
      div_q <= baud_divisor_q;
    end else begin
      div_q <= div_q - 8'h01;
    end
  end

  // frame shape from configuration
  logic [3:0] last_field;
  logic last_stop;
  logic par_bit;
  logic par_calc;
  logic [8:0] data_w;
  always_comb begin
    last_field = ctrl1_q[C1_NINE_BIT] ? 4'd8 : 4'd7;
    if (ctrl1_q[C1_PARITY_EN]) begin
      last_field = last_field + 4'd1;
    end
    last_stop = ctrl1_q[C1_TWO_STOP];
    data_w = ctrl1_q[C1_NINE_BIT] ? word_q[8:0] : {1'b0, word_q[7:0]};
    par_bit = ctrl1_q[C1_NINE_BIT] ? word_q[9] : word_q[8];
    par_calc = ^data_w ^ par_bit ^ ctrl1_q[C1_PARITY_ODD];
  end

  // frame completion at the end of the last stop bit
  logic stop_end;
  logic done;
  logic frame_ferr;
  logic frame_perr;
  logic high_bit;
  always_comb begin
    stop_end = tick & (ovs_q == OVS_LAST) & (state_q == RX_STOP);
    done = stop_end & (stop_idx_q == last_stop);
    frame_ferr = ferr_q | ~bit_val_q;
    frame_perr = ctrl1_q[C1_PARITY_EN] & par_calc;
    high_bit = ctrl1_q[C1_NINE_BIT] ? data_w[8] : data_w[7];
  end

  // oversampling and three-sample majority vote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      votes_q <= 2'd0;
      vote_first_q <= 1'b1;
      bit_val_q <= 1'b1;
      noise_q <= 1'b0;
    end else if (state_q == RX_IDLE) begin
      votes_q <= 2'd0;
      noise_q <= 1'b0;
    end else if (tick && ovs_q >= OVS_FIRST && ovs_q <= OVS_VOTE) begin
      if (ovs_q == OVS_FIRST) begin
        votes_q <= {1'b0, rx_sync_q};
        vote_first_q <= rx_sync_q;
      end else if (ovs_q == OVS_VOTE) begin
        bit_val_q <= (votes_q + {1'b0, rx_sync_q}) >= 2'd2;
        votes_q <= 2'd0;
      end else begin
        votes_q <= votes_q + {1'b0, rx_sync_q};
      end
      // disagreement among the samples marks the frame noisy
      if (ovs_q != OVS_FIRST && rx_sync_q != vote_first_q) begin
        noise_q <= 1'b1;
      end
    end
  end

  // receiver sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RX_IDLE;
      ovs_q <= 4'h0;
      field_q <= 4'h0;
      stop_idx_q <= 1'b0;
      ferr_q <= 1'b0;
      word_q <= 10'h000;
    end else if (!rx_on) begin
      state_q <= RX_IDLE;
      ovs_q <= 4'h0;
    end else if (run) begin
      case (state_q)
        RX_IDLE: begin
          if (fall) begin
            state_q <= RX_START;
            ovs_q <= 4'h0;
            ferr_q <= 1'b0;
          end
        end
        RX_START: begin
          if (tick) begin
            ovs_q <= ovs_q + 4'h1;
            if (ovs_q == OVS_LAST) begin
              // a start bit that votes high was a glitch
              state_q <= bit_val_q ? RX_IDLE : RX_DATA;
              field_q <= 4'h0;
              word_q <= 10'h000;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            ovs_q <= ovs_q + 4'h1;
            if (ovs_q == OVS_LAST) begin
              word_q[field_q] <= bit_val_q; // shift register, lsb first
              field_q <= field_q + 4'h1;
              if (field_q == last_field) begin
                state_q <= RX_STOP;
                stop_idx_q <= 1'b0;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            ovs_q <= ovs_q + 4'h1;
            if (ovs_q == OVS_LAST) begin
              ferr_q <= frame_ferr;
              stop_idx_q <= 1'b1;
              if (done) begin
                // a low line here is a break: wait for it to go high
                state_q <= rx_sync_q ? RX_IDLE : RX_BREAK;
              end
            end
          end
        end
        RX_BREAK: begin
          if (rx_sync_q) begin
            state_q <= RX_IDLE; // no new start until the line is high
          end
        end
        default: state_q <= RX_IDLE;
      endcase
    end
  end

  // two-word buffer; a full buffer drops the new word and flags overrun
  logic full;
  logic push;
  logic wr_idx;
  always_comb begin
    full = (cnt_q == 2'd2) & ~pop;
    push = done & ~full;
    wr_idx = rd_ptr_q ^ cnt_q[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_q[0] <= 12'h000;
      fifo_q[1] <= 12'h000;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        // break frames land here as zeros with framing set
        fifo_q[wr_idx] <= {noise_q, frame_perr, frame_ferr, data_w};
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // overrun flag: a pop in the completing cycle frees a slot, so the flag clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= 1'b0;
    end else if (done & full) begin
      overrun_q <= 1'b1;
    end else if (pop) begin
      overrun_q <= 1'b0;
    end
  end

  // wake-up: falling pin edge while f_H stopped and wake, uart, receive and receive interrupt enables set
  logic wake_ok;
  always_comb begin
    wake_ok = ctrl2_q[C2_WAKE_EN] & sys_q[SYS_UART_ON] & sys_q[SYS_RX_EN] &
              ctrl2_q[C2_RX_INT_EN];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
      wake_pend_q <= 1'b0;
      startup_q <= '0;
    end else begin
      wake_q <= ~fh_running & wake_ok & fall & ~wake_pend_q;
      if (~fh_running & wake_ok & fall) begin
        wake_pend_q <= 1'b1;
      end else if (fh_running & wake_pend_q) begin
        wake_pend_q <= 1'b0;
        startup_q <= STARTUP_LOAD;
      end else if (startup_q != '0) begin
        startup_q <= startup_q - STW'(1);
      end
    end
  end

  // interrupt sources, one low pulse per event
  logic wake_irq;
  logic rx_irq;
  logic tx_irq;
  always_comb begin
    wake_irq = (startup_q == STW'(1)) & sys_q[SYS_GLOBAL_IE] & sys_q[SYS_UART_IE];
    rx_irq = ctrl2_q[C2_RX_INT_EN] &
             ((push & (~ctrl2_q[C2_ADDR_DET] | high_bit)) | (done & full));
    tx_irq = (ctrl2_q[C2_TX_EMPTY_EN] & tx_buf_empty & ~tx_empty_prev_q) |
             (ctrl2_q[C2_TX_IDLE_EN] & tx_idle & ~tx_idle_prev_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_q <= 1'b1;
      tx_empty_prev_q <= 1'b0;
      tx_idle_prev_q <= 1'b0;
    end else begin
      tx_empty_prev_q <= tx_buf_empty;
      tx_idle_prev_q <= tx_idle;
      irq_n_q <= ~(rx_irq | tx_irq | wake_irq);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign uart_irq_n = irq_n_q;
  assign wake_event = wake_q;

endmodule : uart_rx_status_and_wakeup

`default_nettype wire

// *** verif/uart_rx_chk.sv ***
// checker for the receive status block: apb timing, interrupt and wake pulses
// assumes it is bound onto uart_rx_status_and_wakeup and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module uart_rx_chk #(
  parameter int STARTUP_CNT = 5 // clock restart cycles
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic rx_pin, // serial line
  input wire logic fh_running, // uart clock running
  input wire logic tx_buf_empty, // tx empty level
  input wire logic tx_idle, // tx idle level
  input wire logic uart_irq_n, // interrupt pulse
  input wire logic wake_event // wake pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic fh_q; // clock-run level one cycle back
  int unsigned hold_q; // restart cycles still forbidden for an interrupt

  // open a quiet window when the clock comes back; a stale wake must not fire early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fh_q <= 1'b1;
      hold_q <= 0;
    end else begin
      fh_q <= fh_running;
      if (fh_running && !fh_q) begin
        hold_q <= STARTUP_CNT - 1;
      end else if (hold_q != 0) begin
        hold_q <= hold_q - 1;
      end
    end
  end

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response with data or without ready");
  a_irq_low_pulse: assert property (!uart_irq_n |=> uart_irq_n)
    else $error("interrupt low longer than one cycle");
  a_wake_one_pulse: assert property (wake_event |=> !wake_event)
    else $error("wake pulse longer than one cycle");
  a_wake_clock_off: assert property (wake_event |-> !fh_running && !rx_pin)
    else $error("wake without stopped clock and low line");
  a_restart_quiet: assert property (hold_q != 0 |-> uart_irq_n)
    else $error("interrupt inside restart time");

  c_irq: cover property (!uart_irq_n);
  c_wake: cover property (wake_event);
  c_slverr: cover property (pslverr);
  c_read: cover property (pready && !pwrite);
endmodule : uart_rx_chk

bind uart_rx_status_and_wakeup uart_rx_chk #(.STARTUP_CNT(STARTUP_CNT)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_pin(rx_pin), .fh_running(fh_running), .tx_buf_empty(tx_buf_empty),
  .tx_idle(tx_idle), .uart_irq_n(uart_irq_n), .wake_event(wake_event)
);

`default_nettype wire

// *** verif/uart_tx_model.sv ***
// remote serial transmitter driving the receive line
// assumes the bench calls its tasks from a clock edge; baud divisor 0
`timescale 1ns/1ps
`default_nettype none

module uart_tx_model (
  input wire logic clk, // bench clock
  output logic line // receive line, idle high
);
  int bit_cyc = 16; // cycles a bit at divisor 0
  initial line = 1'b1;

  // hold one level for a bit time, changed just after the edge
  task automatic put(input logic v);
    line <= v;
    repeat (bit_cyc) @(posedge clk);
  endtask : put

  // one bit with a one-cycle dip near its middle, to upset the vote
  task automatic put_dip(input logic v);
    line <= v;
    repeat (bit_cyc / 2) @(posedge clk);
    line <= ~v;
    @(posedge clk);
    line <= v;
    repeat (bit_cyc / 2 - 1) @(posedge clk);
  endtask : put_dip

  // one frame lsb first; flip spoils parity, st gives the stop levels
  task automatic send(input logic [8:0] d, input logic nine, pe, odd, flip,
                      input logic [1:0] st, input logic two);
    logic p;
    p = odd;
    @(posedge clk);
    put(1'b0);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      put(d[i]);
      p = p ^ d[i];
    end
    if (pe) put(p ^ flip);
    put(st[0]);
    if (two) put(st[1]);
    put(1'b1); // idle bit so a break ends and the next start is seen
  endtask : send
endmodule : uart_tx_model

`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench: apb register tasks, serial frames from the model
// assumes design package constants and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import uart_rx_pkg::*;
  localparam int SU = 5; // short restart count
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, uart_irq_n, wake_event, rx_pin;
  logic fh_running = 1'b1, tx_buf_empty = 1'b0, tx_idle = 1'b0;
  logic [31:0] error_cnt = 0, check_count = 0, irq_cnt = 0, wake_cnt = 0, cyc = 0;
  logic [8:0] ad_d [5] = '{9'h0ff, 9'h100, 9'h080, 9'h07f, 9'h07f};
  logic [4:0] ad_9 = 5'b00011, ad_i = 5'b10110;

  always #5 pclk = ~pclk;

  uart_rx_status_and_wakeup #(.STARTUP_CNT(SU)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .fh_running(fh_running), .tx_buf_empty(tx_buf_empty),
    .tx_idle(tx_idle), .uart_irq_n(uart_irq_n), .wake_event(wake_event)
  );
  uart_tx_model tx_u (.clk(pclk), .line(rx_pin));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // count pulses; the cycle ceiling cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (uart_irq_n === 1'b0) irq_cnt <= irq_cnt + 1;
    if (wake_event === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count = check_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h1, n);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] m, exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk($sformatf("reg %h", a), exp, rd & m);
  endtask : rc

  // status access arms the pop; the data read then takes the head word
  task automatic pop(input logic [8:0] d);
    rc(STATUS_OFF, 32'h1, 32'h1);
    rc(DATA_OFF, 32'h1ff, {23'h0, d});
  endtask : pop

  task automatic s8(input logic [8:0] d);
    tx_u.send(d, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11, 1'b0);
  endtask : s8

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial begin
    logic [31:0] i0, w0, rd;
    logic e;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rc(STATUS_OFF, 32'h1f, 32'h0);
    rc(CTRL2_OFF, 32'h1f, 32'h0);
    rc(SYS_OFF, 32'hf, 32'h0);
    apb(1'b0, 8'h20, 32'h0, rd, e);
    chk("slverr", 32'h1, {31'h0, e});
    wr(STATUS_OFF, 32'hff);
    rc(STATUS_OFF, 32'h1f, 32'h0);
    done("reset");
    wr(BAUD_OFF, 32'h0);
    wr(SYS_OFF, 32'h3);
    wr(CTRL2_OFF, 32'h1);
    i0 = irq_cnt;
    fork
      s8(9'h0a5);
      begin
        repeat (60) @(posedge pclk);
        rc(STATUS_OFF, 32'h20, 32'h0);
      end
    join
    rc(STATUS_OFF, 32'h21, 32'h21);
    chk("irq", i0 + 1, irq_cnt);
    pop(9'h0a5);
    rc(STATUS_OFF, 32'h1, 32'h0);
    done("single");
    i0 = irq_cnt;
    for (int k = 1; k < 4; k++) s8(9'(k * 17));
    chk("irq", i0 + 3, irq_cnt);
    rc(STATUS_OFF, 32'h3, 32'h3);
    rc(DATA_OFF, 32'h1ff, 32'h011);
    rc(STATUS_OFF, 32'h3, 32'h1);
    pop(9'h022);
    rc(STATUS_OFF, 32'h1, 32'h0);
    done("overrun");
    tx_u.send(9'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 1'b0);
    rc(STATUS_OFF, 32'h31, 32'h31);
    pop(9'h0);
    wr(CTRL1_OFF, 32'h2);
    for (int k = 0; k < 2; k++) begin
      tx_u.send(9'h055, 1'b0, 1'b0, 1'b0, 1'b0, {k[0], 1'b1}, 1'b1);
      rc(STATUS_OFF, 32'h11, {27'h0, ~k[0], 4'h1});
      pop(9'h055);
    end
    done("framing");
    tx_u.send(9'h055, 1'b0, 1'b0, 1'b0, 1'b0, 2'b01, 1'b1);
    rc(STATUS_OFF, 32'h11, 32'h11);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(STATUS_OFF, 32'h1f, 32'h0);
    rc(CTRL1_OFF, 32'h1f, 32'h0);
    wr(SYS_OFF, 32'h3);
    wr(CTRL2_OFF, 32'h1);
    done("reset again");
    for (int k = 0; k < 4; k++) begin
      wr(CTRL1_OFF, {28'h0, 1'b1, k[1], 2'b00});
      tx_u.send(9'h013, 1'b0, 1'b1, k[1], k[0], 2'b11, 1'b0);
      rc(STATUS_OFF, 32'h19, {27'h0, 1'b0, k[0], 3'b001});
      pop(9'h013);
    end
    done("parity");
    // bit 0 carries a one-cycle dip: the vote keeps it, the frame is noisy
    wr(CTRL1_OFF, 32'h0);
    i0 = irq_cnt;
    tx_u.put(1'b0);
    tx_u.put_dip(1'b1);
    repeat (9) tx_u.put(1'b1);
    s8(9'h03c);
    chk("irq", i0 + 2, irq_cnt);
    rc(STATUS_OFF, 32'h5, 32'h5);
    pop(9'h0ff);
    rc(STATUS_OFF, 32'h5, 32'h1);
    pop(9'h03c);
    done("noise");
    for (int k = 0; k < 5; k++) begin
      wr(CTRL2_OFF, (k == 4) ? 32'h1 : 32'h9);
      wr(CTRL1_OFF, {27'h0, ad_9[k], 4'h0});
      i0 = irq_cnt;
      tx_u.send(ad_d[k], ad_9[k], 1'b0, 1'b0, 1'b0, 2'b11, 1'b0);
      chk("irq", i0 + ad_i[k], irq_cnt);
      rc(CTRL1_OFF, 32'h1, {31'h0, ad_d[k][8]});
      pop(ad_d[k]);
    end
    done("address");
    wr(CTRL1_OFF, 32'h0);
    wr(CTRL2_OFF, 32'h6);
    i0 = irq_cnt;
    tx_buf_empty <= 1'b1;
    repeat (4) @(posedge pclk);
    tx_idle <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("irq", i0 + 2, irq_cnt);
    rc(STATUS_OFF, 32'hc0, 32'hc0);
    wr(CTRL2_OFF, 32'h0);
    tx_buf_empty <= 1'b0;
    repeat (2) @(posedge pclk);
    tx_buf_empty <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("irq", i0 + 2, irq_cnt);
    done("transmit");
    wr(CTRL2_OFF, 32'h11);
    wr(SYS_OFF, 32'hf);
    for (int k = 0; k < 2; k++) begin
      i0 = irq_cnt;
      w0 = wake_cnt;
      fh_running <= 1'b0;
      tx_u.put(1'b0);
      tx_u.put(1'b1);
      chk("wake", w0 + 1, wake_cnt);
      chk("irq", i0, irq_cnt);
      rc(CTRL2_OFF, 32'h1f, 32'h11);
      fh_running <= 1'b1;
      // line low across the restart: a frame here must not be taken
      tx_u.put(1'b0);
      repeat (12) tx_u.put(1'b1);
      chk("irq", i0 + 1 - k, irq_cnt);
      rc(STATUS_OFF, 32'h21, 32'h20);
      wr(SYS_OFF, 32'h3);
    end
    done("wake");
    stop_test();
  end
endmodule : testbench

`default_nettype wire
